// ### design/iepb_arb.sv
// Picks the best eligible pending source by level, then by polling order.
`timescale 1ns/10ps
`default_nettype none

module iepb_arb #(
    parameter int NUM_SRC = 13
) (
    // Pending sources and their levels.
    input wire logic [NUM_SRC-1:0] pend_in,
    input wire iepb_pkg::iepb_level_t [NUM_SRC-1:0] level_in,
    // Level of the handler now running.
    input wire logic floor_valid_in,
    input wire iepb_pkg::iepb_level_t floor_level_in,
    // Chosen request.
    output var iepb_pkg::iepb_grant_s grant_out
);

    // The source code is four bits wide.
    if (NUM_SRC < 1 || NUM_SRC > 16) begin : g_bad_count
        $error("iepb_arb: source count must lie in 1..16");
    end

    // Scan in polling order; a strict compare keeps the earlier source on a tie.
    always_comb begin
        grant_out = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (pend_in[i] && (!floor_valid_in || level_in[i] > floor_level_in)
                && (!grant_out.valid || level_in[i] > grant_out.level)) begin
                grant_out.valid = 1'b1;
                grant_out.source = iepb_pkg::iepb_src_e'(i[3:0]);
                grant_out.level = level_in[i];
            end
        end
    end

endmodule

`default_nettype wire

// ### design/iepb_isr.sv
// Tracks which priority levels have a handler in service.
`timescale 1ns/10ps
`default_nettype none

module iepb_isr #(
    parameter int NUM_LEVELS = 4
) (
    // Clock and synchronous reset.
    input wire logic clock_in,
    input wire logic reset_in,
    // Vector taken and handler return.
    input wire logic push_in,
    input wire iepb_pkg::iepb_level_t push_level_in,
    input wire logic pop_in,
    // Highest level in service.
    output logic active_out,
    output iepb_pkg::iepb_level_t level_out
);

    // The level type is two bits wide.
    if (NUM_LEVELS < 2 || NUM_LEVELS > 4) begin : g_bad_levels
        $error("iepb_isr: level count must lie in 2..4");
    end

    logic [NUM_LEVELS-1:0] busy_reg;
    logic [NUM_LEVELS-1:0] busy_next;

    // The highest busy level is the one that a return ends.
    always_comb begin
        active_out = |busy_reg;
        level_out = '0;
        for (int l = 0; l < NUM_LEVELS; l++) begin
            if (busy_reg[l]) begin
                level_out = iepb_pkg::iepb_level_t'(l);
            end
        end
        busy_next = busy_reg;
        if (pop_in) begin
            busy_next[level_out] = 1'b0;
        end
        if (push_in) begin
            busy_next[push_level_in] = 1'b1;
        end
    end

    // Nested levels stay marked until their own return.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            busy_reg <= '0;
        end else begin
            busy_reg <= busy_next;
        end
    end

endmodule

`default_nettype wire

// ### design/iepb_top.sv
// Interrupt enable and priority register bank with request arbitration.
`timescale 1ns/10ps
`default_nettype none

module iepb_top (
    // Clock and synchronous reset.
    input wire logic clock_in,
    input wire logic reset_in,
    // Special function register access from the core.
    input wire iepb_pkg::iepb_sfr_req_s sfr_req_in,
    output logic [7:0] sfr_rdata_out,
    output logic sfr_hit_out,
    // Requests from the peripherals, in polling order.
    input wire logic [iepb_pkg::NUM_SRC-1:0] irq_req_in,
    // Vector handshake with the core.
    input wire logic irq_ack_in,
    input wire logic irq_reti_in,
    output var iepb_pkg::iepb_grant_s irq_grant_out
);

    localparam int NSRC = iepb_pkg::NUM_SRC;

    // Fields of the bus request.
    logic [7:0] addr_w;
    logic [7:0] wdata_w;
    logic wr_w;
    logic rd_w;

    assign addr_w = sfr_req_in.addr;
    assign wdata_w = sfr_req_in.wdata;
    assign wr_w = sfr_req_in.wr;
    assign rd_w = sfr_req_in.rd;

    // Register bank.
    logic [7:0] en0_reg;
    logic [7:0] en1_reg;
    logic [7:0] ph0_reg;
    logic [7:0] pl0_reg;
    logic [7:0] ph1_reg;
    logic [7:0] pl1_reg;

    // Read port flip-flops.
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic hit_reg;
    logic hit_next;

    // Request offered to the core.
    iepb_pkg::iepb_grant_s grant_reg;
    iepb_pkg::iepb_grant_s grant_w;

    // Per-source views of the bank, in polling order.
    logic [NSRC-1:0] en_vec;
    logic [NSRC-1:0] ph_vec;
    logic [NSRC-1:0] pl_vec;
    logic [NSRC-1:0] pend_w;
    iepb_pkg::iepb_level_t [NSRC-1:0] level_w;

    // In-service state.
    logic run_active_w;
    iepb_pkg::iepb_level_t run_level_w;

    // Spreads the two group registers over the polling order.
    // Group 1 skips its reserved bit 5, so usb lands after keypad.
    function automatic logic [NSRC-1:0] gather(
        input logic [7:0] g0,
        input logic [7:0] g1
    );
        gather = {g1[iepb_pkg::G1_USB_BIT],
                  g1[iepb_pkg::G1_LOW_W-1:0],
                  g0[iepb_pkg::G0_SRC_W-1:0]};
    endfunction

    // Enable register 0 holds the gate and the group 0 enables.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            en0_reg <= iepb_pkg::REG_RESET;
        end else if (wr_w && addr_w == iepb_pkg::ADDR_EN0) begin
            en0_reg <= wdata_w;
        end
    end

    // Enable register 1; reserved bits never store a one.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            en1_reg <= iepb_pkg::REG_RESET;
        end else if (wr_w && addr_w == iepb_pkg::ADDR_EN1) begin
            en1_reg <= wdata_w & ~iepb_pkg::G1_RSVD_MASK;
        end
    end

    // Group 0 priority-high bits; bit 7 is dropped so it reads zero.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ph0_reg <= iepb_pkg::REG_RESET;
        end else if (wr_w && addr_w == iepb_pkg::ADDR_PH0) begin
            ph0_reg <= wdata_w & ~iepb_pkg::G0_PRIO_RSVD_MASK;
        end
    end

    // Group 0 priority-low bits.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pl0_reg <= iepb_pkg::REG_RESET;
        end else if (wr_w && addr_w == iepb_pkg::ADDR_PL0) begin
            pl0_reg <= wdata_w & ~iepb_pkg::G0_PRIO_RSVD_MASK;
        end
    end

    // Group 1 priority-high bits.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ph1_reg <= iepb_pkg::REG_RESET;
        end else if (wr_w && addr_w == iepb_pkg::ADDR_PH1) begin
            ph1_reg <= wdata_w & ~iepb_pkg::G1_RSVD_MASK;
        end
    end

    // Group 1 priority-low bits.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pl1_reg <= iepb_pkg::REG_RESET;
        end else if (wr_w && addr_w == iepb_pkg::ADDR_PL1) begin
            pl1_reg <= wdata_w & ~iepb_pkg::G1_RSVD_MASK;
        end
    end

    // Read decode; an unmapped address answers zero with no hit.
    always_comb begin
        rdata_next = iepb_pkg::REG_RESET;
        hit_next = 1'b1;
        if (addr_w == iepb_pkg::ADDR_EN0) begin
            rdata_next = en0_reg;
        end else if (addr_w == iepb_pkg::ADDR_EN1) begin
            rdata_next = en1_reg;
        end else if (addr_w == iepb_pkg::ADDR_PH0) begin
            rdata_next = ph0_reg;
        end else if (addr_w == iepb_pkg::ADDR_PL0) begin
            rdata_next = pl0_reg;
        end else if (addr_w == iepb_pkg::ADDR_PH1) begin
            rdata_next = ph1_reg;
        end else if (addr_w == iepb_pkg::ADDR_PL1) begin
            rdata_next = pl1_reg;
        end else begin
            hit_next = 1'b0;
        end
    end

    // Read data is held until the next read so a slow core can sample late.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rdata_reg <= iepb_pkg::REG_RESET;
            hit_reg <= 1'b0;
        end else begin
            hit_reg <= rd_w && hit_next;
            if (rd_w) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign sfr_rdata_out = rdata_reg;
    assign sfr_hit_out = hit_reg;

    // Requests pass only through an open gate and their own enable.
    assign en_vec = gather(en0_reg, en1_reg);
    assign ph_vec = gather(ph0_reg, ph1_reg);
    assign pl_vec = gather(pl0_reg, pl1_reg);
    assign pend_w = irq_req_in & en_vec & {NSRC{en0_reg[iepb_pkg::GATE_BIT]}};

    // Each level is its high bit over its low bit.
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            level_w[i] = {ph_vec[i], pl_vec[i]};
        end
    end

    // Levels already in service act as the floor for new requests.
    iepb_isr #(
        .NUM_LEVELS(4)
    ) u_isr (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .push_in(irq_ack_in && grant_reg.valid),
        .push_level_in(grant_reg.level),
        .pop_in(irq_reti_in),
        .active_out(run_active_w),
        .level_out(run_level_w)
    );

    // Arbitration between the eligible sources.
    iepb_arb #(
        .NUM_SRC(NSRC)
    ) u_arb (
        .pend_in(pend_w),
        .level_in(level_w),
        .floor_valid_in(run_active_w),
        .floor_level_in(run_level_w),
        .grant_out(grant_w)
    );

    // The offer drops for one cycle after it is taken, so the floor can
    // catch up before the next offer; this costs one cycle of latency.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            grant_reg <= '0;
        end else if (irq_ack_in) begin
            grant_reg <= '0;
        end else begin
            grant_reg <= grant_w;
        end
    end

    assign irq_grant_out = grant_reg;

    // Helper state that only the checks below read.
    logic [NSRC-1:0] en_seen_reg;
    logic [NSRC-1:0] ph_seen_reg;
    logic [NSRC-1:0] pl_seen_reg;
    logic better_w;

    // Any eligible source that should have beaten the chosen one.
    always_comb begin
        better_w = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (pend_w[i] && (!run_active_w || level_w[i] > run_level_w)) begin
                if (!grant_w.valid || level_w[i] > grant_w.level
                    || (level_w[i] == grant_w.level && i < int'(grant_w.source))) begin
                    better_w = 1'b1;
                end
            end
        end
    end

    // Snapshot of the views that each offer was computed from.
    always_ff @(posedge clock_in) begin
        en_seen_reg <= en_vec;
        ph_seen_reg <= ph_vec;
        pl_seen_reg <= pl_vec;
    end

    // A closed gate never lets an offer out.
    chk_gate_blocks: assert property (@(posedge clock_in) disable iff (reset_in)
        !en0_reg[iepb_pkg::GATE_BIT] |=> !irq_grant_out.valid)
        else $error("offer made while the master gate was closed");

    // Every offer belongs to a source that was enabled.
    chk_source_enabled: assert property (@(posedge clock_in) disable iff (reset_in)
        irq_grant_out.valid |-> en_seen_reg[irq_grant_out.source])
        else $error("offer made for a disabled source");

    // Enable register 0 reads back what was written.
    chk_en0_readback: assert property (@(posedge clock_in) disable iff (reset_in)
        (wr_w && addr_w == iepb_pkg::ADDR_EN0)
        ##1 (rd_w && !wr_w && addr_w == iepb_pkg::ADDR_EN0)
        |=> sfr_rdata_out == $past(wdata_w, 2) && sfr_hit_out)
        else $error("enable register 0 readback mismatch");

    // Enable register 1 reads back the written bits outside the reserved ones.
    chk_en1_readback: assert property (@(posedge clock_in) disable iff (reset_in)
        (wr_w && addr_w == iepb_pkg::ADDR_EN1)
        ##1 (rd_w && !wr_w && addr_w == iepb_pkg::ADDR_EN1)
        |=> sfr_rdata_out == ($past(wdata_w, 2) & ~iepb_pkg::G1_RSVD_MASK))
        else $error("enable register 1 readback mismatch");

    // Reserved group 1 bits read as zero.
    chk_g1_rsvd_zero: assert property (@(posedge clock_in) disable iff (reset_in)
        rd_w && (addr_w == iepb_pkg::ADDR_EN1 || addr_w == iepb_pkg::ADDR_PH1
                 || addr_w == iepb_pkg::ADDR_PL1)
        |=> (sfr_rdata_out & iepb_pkg::G1_RSVD_MASK) == 8'h00)
        else $error("reserved group 1 bit read as one");

    // Reserved group 0 priority bit reads as zero here.
    chk_g0_rsvd_zero: assert property (@(posedge clock_in) disable iff (reset_in)
        rd_w && (addr_w == iepb_pkg::ADDR_PH0 || addr_w == iepb_pkg::ADDR_PL0)
        |=> (sfr_rdata_out & iepb_pkg::G0_PRIO_RSVD_MASK) == 8'h00)
        else $error("reserved group 0 priority bit read as one");

    // Priority-high 0 reads back its written bits.
    chk_ph0_readback: assert property (@(posedge clock_in) disable iff (reset_in)
        (wr_w && addr_w == iepb_pkg::ADDR_PH0)
        ##1 (rd_w && !wr_w && addr_w == iepb_pkg::ADDR_PH0)
        |=> sfr_rdata_out == ($past(wdata_w, 2) & ~iepb_pkg::G0_PRIO_RSVD_MASK))
        else $error("priority-high 0 readback mismatch");

    // Priority-low 0 reads back its written bits.
    chk_pl0_readback: assert property (@(posedge clock_in) disable iff (reset_in)
        (wr_w && addr_w == iepb_pkg::ADDR_PL0)
        ##1 (rd_w && !wr_w && addr_w == iepb_pkg::ADDR_PL0)
        |=> sfr_rdata_out == ($past(wdata_w, 2) & ~iepb_pkg::G0_PRIO_RSVD_MASK))
        else $error("priority-low 0 readback mismatch");

    // Priority-high 1 reads back its written bits.
    chk_ph1_readback: assert property (@(posedge clock_in) disable iff (reset_in)
        (wr_w && addr_w == iepb_pkg::ADDR_PH1)
        ##1 (rd_w && !wr_w && addr_w == iepb_pkg::ADDR_PH1)
        |=> sfr_rdata_out == ($past(wdata_w, 2) & ~iepb_pkg::G1_RSVD_MASK))
        else $error("priority-high 1 readback mismatch");

    // Priority-low 1 reads back its written bits.
    chk_pl1_readback: assert property (@(posedge clock_in) disable iff (reset_in)
        (wr_w && addr_w == iepb_pkg::ADDR_PL1)
        ##1 (rd_w && !wr_w && addr_w == iepb_pkg::ADDR_PL1)
        |=> sfr_rdata_out == ($past(wdata_w, 2) & ~iepb_pkg::G1_RSVD_MASK))
        else $error("priority-low 1 readback mismatch");

    // The offered level is the source's high bit over its low bit.
    chk_level_form: assert property (@(posedge clock_in) disable iff (reset_in)
        irq_grant_out.valid |-> irq_grant_out.level
            == {ph_seen_reg[irq_grant_out.source], pl_seen_reg[irq_grant_out.source]})
        else $error("offered level does not match the priority bits");

    // A handler in service is preempted only from a strictly higher level.
    chk_preempt_above: assert property (@(posedge clock_in) disable iff (reset_in)
        irq_grant_out.valid && $past(run_active_w)
        |-> irq_grant_out.level > $past(run_level_w))
        else $error("offer at or below the level in service");

    // No eligible source outranked the one offered.
    chk_best_chosen: assert property (@(posedge clock_in) disable iff (reset_in)
        irq_grant_out.valid |-> !$past(better_w))
        else $error("offer lost to level or polling order");

    // After reset the bank is clear and nothing is offered.
    chk_reset_clear: assert property (@(posedge clock_in)
        $past(reset_in) && !reset_in |-> en0_reg == 8'h00 && en1_reg == 8'h00
            && ph0_reg == 8'h00 && pl0_reg == 8'h00 && ph1_reg == 8'h00
            && pl1_reg == 8'h00 && !irq_grant_out.valid)
        else $error("bank not clear after reset");

endmodule

`default_nettype wire

// ### shared/iepb_pkg.sv
// Constants, types and field layout shared by the interrupt enable and priority bank.
package iepb_pkg;

    // Register addresses on the special function register bus.
    localparam logic [7:0] ADDR_EN0 = 8'ha8;
    localparam logic [7:0] ADDR_EN1 = 8'hb1;
    localparam logic [7:0] ADDR_PL1 = 8'hb2;
    localparam logic [7:0] ADDR_PH1 = 8'hb3;
    localparam logic [7:0] ADDR_PH0 = 8'hb7;
    localparam logic [7:0] ADDR_PL0 = 8'hb8;

    // Reset value and reserved-bit masks.
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] G1_RSVD_MASK = 8'ha0;
    localparam logic [7:0] G0_PRIO_RSVD_MASK = 8'h80;

    // Field positions.
    localparam int GATE_BIT = 7;
    localparam int G0_SRC_W = 7;
    localparam int G1_LOW_W = 5;
    localparam int G1_USB_BIT = 6;
    localparam int NUM_SRC = 13;

    // Sources in polling order, first entry wins a tie.
    typedef enum logic [3:0] {
        SRC_EXT0, SRC_TIMER0, SRC_EXT1, SRC_TIMER1, SRC_UART, SRC_DECODER,
        SRC_AUDIO, SRC_CARD, SRC_TWOWIRE, SRC_SPI, SRC_CONVERTER, SRC_KEYPAD, SRC_USB
    } iepb_src_e;

    typedef logic [1:0] iepb_level_t;

    // One access from the core to the register bank.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } iepb_sfr_req_s;

    // Request offered to the core.
    typedef struct packed {
        logic valid;
        iepb_src_e source;
        iepb_level_t level;
    } iepb_grant_s;

endpackage

// ### sim/iepb_core_model.sv
// Behavioural model of the core side: takes offered vectors and returns from handlers on command.
`timescale 1ns/10ps
`default_nettype none

module iepb_core_model (
    // Clock and synchronous reset.
    input wire logic clock_in,
    input wire logic reset_in,
    // Commands from the bench: take one offer after a delay, or return from a handler.
    input wire logic take_in,
    input wire logic [1:0] delay_in,
    input wire logic return_in,
    // Offer from the bank and the handshake back to it.
    input wire iepb_pkg::iepb_grant_s irq_grant_in,
    output logic irq_ack_out,
    output logic irq_reti_out
);
    logic pend;
    logic [1:0] wait_cnt;
    int depth;

    // Quiet handshake lines from time zero, before the first falling edge.
    initial begin
        irq_ack_out = 1'b0;
        irq_reti_out = 1'b0;
    end

    // Acknowledge only while an offer is valid, and return only as often as offers were taken.
    always @(negedge clock_in) begin
        irq_ack_out <= 1'b0;
        irq_reti_out <= 1'b0;
        if (reset_in) begin
            pend <= 1'b0;
            wait_cnt <= 2'h0;
            depth <= 0;
        end else begin
            if (take_in) begin
                pend <= 1'b1;
                wait_cnt <= delay_in;
            end else if (pend && irq_grant_in.valid === 1'b1) begin
                if (wait_cnt != 2'h0) begin
                    wait_cnt <= wait_cnt - 2'h1; // A slow core lets the offer stand a while.
                end else begin
                    irq_ack_out <= 1'b1;
                    pend <= 1'b0;
                    depth <= depth + 1;
                end
            end
            if (return_in && depth > 0) begin
                irq_reti_out <= 1'b1;
                depth <= depth - 1;
            end
        end
    end
endmodule

`default_nettype wire

// ### sim/iepb_top_test.sv
// Self-checking bench for the interrupt enable and priority bank.
`timescale 1ns/10ps
`default_nettype none

module iepb_top_test;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    iepb_pkg::iepb_sfr_req_s sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    logic [12:0] irq_req = 13'h0000;
    logic irq_ack;
    logic irq_reti;
    logic take = 1'b0;
    logic ret = 1'b0;
    logic [1:0] delay = 2'h0;
    iepb_pkg::iepb_grant_s irq_grant;
    int miscompares = 0;
    int compares = 0;
    int seed = 42;
    int cycles = 0;
    logic [31:0] rv;
    int idx;
    logic [7:0] sh [6];
    logic [7:0] addrs [6];
    logic [7:0] masks [6];
    int floor_q [$];

    iepb_top u_dut (.clock_in(clock_in), .reset_in(reset_in), .sfr_req_in(sfr_req), .sfr_rdata_out(sfr_rdata),
        .sfr_hit_out(sfr_hit), .irq_req_in(irq_req), .irq_ack_in(irq_ack), .irq_reti_in(irq_reti),
        .irq_grant_out(irq_grant));

    iepb_core_model u_core (.clock_in(clock_in), .reset_in(reset_in), .take_in(take), .delay_in(delay),
        .return_in(ret), .irq_grant_in(irq_grant), .irq_ack_out(irq_ack), .irq_reti_out(irq_reti));

    // Free-running 25 MHz clock.
    initial begin
        forever #20 clock_in = ~clock_in;
    end

    // The whole run needs well under 1000 cycles, so 6000 means something hangs.
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Reserved bits never hold a one, so the shadow keeps only what the bank stores.
    // A strobe stays up between back-to-back accesses of one kind; the next other task lowers it,
    // so no strobe is ever dropped and raised again within one time step.
    task automatic wr(input int i, input logic [7:0] d);
        sfr_req.addr = addrs[i];
        sfr_req.wdata = d;
        sfr_req.rd = 1'b0;
        sfr_req.wr = 1'b1;
        @(negedge clock_in);
        sh[i] = d & masks[i];
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        sfr_req.addr = a;
        sfr_req.wr = 1'b0;
        sfr_req.rd = 1'b1;
        @(negedge clock_in);
        check(sfr_rdata, exp, "read data");
        check({7'h00, sfr_hit}, {7'h00, hit}, "hit pulse");
    endtask

    // Best eligible source: highest level, lowest polling index on a tie, above any level in service.
    function automatic logic [6:0] exp_grant(input logic [12:0] r);
        logic [6:0] g;
        logic [1:0] lv;
        logic en;
        int b;
        int best;
        g = 7'h00;
        best = -1;
        for (int i = 0; i < 13; i++) begin
            b = (i < 7) ? i : ((i == 12) ? 6 : i - 7);
            lv = (i < 7) ? {sh[4][b], sh[5][b]} : {sh[3][b], sh[2][b]};
            en = (i < 7) ? sh[0][b] : sh[1][b];
            if (r[i] && sh[0][7] && en && (floor_q.size() == 0 || lv > floor_q[$]) && int'(lv) > best) begin
                best = int'(lv);
                g = {1'b1, 4'(i), lv};
            end
        end
        return g;
    endfunction

    task automatic offer(input logic [12:0] r);
        sfr_req.wr = 1'b0;
        sfr_req.rd = 1'b0;
        irq_req = r;
        repeat (2) @(negedge clock_in);
        check({1'b0, irq_grant}, {1'b0, exp_grant(r)}, "offer");
    endtask

    task automatic take_one(input logic [1:0] d);
        logic [6:0] g;
        g = exp_grant(irq_req);
        delay = d;
        take <= 1'b1;
        @(negedge clock_in);
        take <= 1'b0;
        repeat (d + 2) @(negedge clock_in);
        floor_q.push_back(int'(g[1:0]));
    endtask

    task automatic give_back();
        ret <= 1'b1;
        @(negedge clock_in);
        ret <= 1'b0;
        void'(floor_q.pop_back());
        repeat (3) @(negedge clock_in);
    endtask

    // Main sequence, driven on falling edges.
    initial begin
        addrs = '{iepb_pkg::ADDR_EN0, iepb_pkg::ADDR_EN1, iepb_pkg::ADDR_PL1, iepb_pkg::ADDR_PH1,
            iepb_pkg::ADDR_PH0, iepb_pkg::ADDR_PL0};
        masks = '{8'hff, 8'h5f, 8'h5f, 8'h5f, 8'h7f, 8'h7f};
        repeat (3) @(negedge clock_in);
        reset_in = 1'b0;
        for (int i = 0; i < 6; i++) begin
            sh[i] = 8'h00;
            rd(addrs[i], 8'h00, 1'b1);
        end
        rd(8'hb4, 8'h00, 1'b0);
        check({1'b0, irq_grant}, 8'h00, "grant after reset");
        $display("reset values done");
        // Ones written to reserved bits on purpose must not be kept.
        for (int i = 0; i < 6; i++) begin
            wr(i, 8'hff);
            rd(addrs[i], masks[i], 1'b1);
            wr(i, 8'h00);
        end
        $display("reserved bits done");
        wr(0, 8'hff);
        wr(1, 8'h5f);
        for (int i = 0; i < 13; i++) begin
            offer(13'h0001 << i);
        end
        offer(13'h1fff);
        wr(0, 8'h7f);
        offer(13'h1fff);
        wr(0, 8'hff);
        wr(3, 8'h40);
        wr(2, 8'h40);
        offer(13'h1fff);
        $display("polling order done");
        for (int n = 0; n < 80; n++) begin
            rv = $random(seed);
            idx = int'(rv[31:24]) % 6;
            wr(idx, rv[7:0] & masks[idx]);
            offer(rv[20:8]);
            rd(addrs[idx], sh[idx], 1'b1);
        end
        $display("random traffic done");
        wr(0, 8'h81);
        wr(1, 8'h40);
        for (int i = 2; i < 6; i++) begin
            wr(i, 8'h00);
        end
        offer(13'h0001);
        take_one(2'h0);
        offer(13'h0001);
        offer(13'h1001);
        wr(3, 8'h40);
        wr(2, 8'h40);
        offer(13'h1001);
        take_one(2'h2);
        offer(13'h1001);
        give_back();
        offer(13'h1001);
        give_back();
        offer(13'h1001);
        $display("preemption done");
        // A reset in mid-run, with a handler in service, must clear the bank and the floor.
        take_one(2'h0);
        reset_in = 1'b1;
        repeat (3) @(negedge clock_in);
        reset_in = 1'b0;
        floor_q.delete();
        for (int i = 0; i < 6; i++) begin
            sh[i] = 8'h00;
            rd(addrs[i], 8'h00, 1'b1);
        end
        check({1'b0, irq_grant}, 8'h00, "grant after second reset");
        wr(0, 8'h81);
        offer(13'h0001);
        $display("mid-run reset done");
        conclude();
    end
endmodule

`default_nettype wire
